// [scan_pkg.sv]
package scan_pkg;

   // ==========================================================
   // Register widths, queue depth and reset high count
   localparam int IR_W = 3;
   localparam int BSR_LEN = 273;
   localparam int XFER_DEPTH = 4;
   localparam int TLR_HIGH_COUNT = 5;

   // ==========================================================
   // Instruction codes
   localparam logic [IR_W-1:0] INSN_EXTEST = 3'h0;
   localparam logic [IR_W-1:0] INSN_SAMPLE = 3'h5;
   localparam logic [IR_W-1:0] INSN_BYPASS = 3'h7;

   // ==========================================================
   // Capture and reset values
   localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;
   localparam logic [IR_W-1:0] IR_RESET_VAL = 3'h7;
   localparam logic BYPASS_CAPTURE_VAL = 1'h0;

   // ==========================================================
   // Test access controller states
   typedef enum logic [3:0] {
      st_tlr, st_idle,
      st_sel_dr, st_cap_dr, st_shift_dr, st_ex1_dr, st_pause_dr, st_ex2_dr, st_upd_dr,
      st_sel_ir, st_cap_ir, st_shift_ir, st_ex1_ir, st_pause_ir, st_ex2_ir, st_upd_ir
   } tap_state_t;

endpackage

// [xfer_fifo.sv]
`timescale 1ns/1ps

module xfer_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   // Write side
   input wire logic i_wclk,
   input wire logic i_wrst,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [W-1:0] i_wdata,
   // Read side
   input wire logic i_rclk,
   input wire logic i_rrst,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [W-1:0] o_rdata
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wbin_r, wgray_r, rbin_r, rgray_r;
   logic [AW:0] rgray_meta_r, rgray_sync_r, wgray_meta_r, wgray_sync_r;
   logic [AW:0] wbin_nxt, rbin_nxt;
   logic wfull, rempty, wpush, rpop;

   // ==========================================================
   // Write domain
   assign wfull = (wgray_r == {~rgray_sync_r[AW:AW-1], rgray_sync_r[AW-2:0]});
   assign o_wready = !wfull;
   assign wpush = i_wvalid && !wfull;
   assign wbin_nxt = wbin_r + (AW+1)'(1);

   // Storage write
   always_ff @(posedge i_wclk)
   begin
      if (wpush)
      begin
         mem[wbin_r[AW-1:0]] <= i_wdata;
      end
   end

   // Write pointer, binary and gray
   always_ff @(posedge i_wclk)
   begin
      if (i_wrst)
      begin
         wbin_r <= '0;
         wgray_r <= '0;
      end
      else if (wpush)
      begin
         wbin_r <= wbin_nxt;
         wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      end
   end

   // Read pointer into write domain
   always_ff @(posedge i_wclk)
   begin
      if (i_wrst)
      begin
         rgray_meta_r <= '0;
         rgray_sync_r <= '0;
      end
      else
      begin
         rgray_meta_r <= rgray_r;
         rgray_sync_r <= rgray_meta_r;
      end
   end

   // ==========================================================
   // Read domain
   assign rempty = (rgray_r == wgray_sync_r);
   assign o_rvalid = !rempty;
   assign rpop = i_rready && !rempty;
   assign rbin_nxt = rbin_r + (AW+1)'(1);
   assign o_rdata = mem[rbin_r[AW-1:0]];

   // Read pointer, binary and gray
   always_ff @(posedge i_rclk)
   begin
      if (i_rrst)
      begin
         rbin_r <= '0;
         rgray_r <= '0;
      end
      else if (rpop)
      begin
         rbin_r <= rbin_nxt;
         rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      end
   end

   // Write pointer into read domain
   always_ff @(posedge i_rclk)
   begin
      if (i_rrst)
      begin
         wgray_meta_r <= '0;
         wgray_sync_r <= '0;
      end
      else
      begin
         wgray_meta_r <= wgray_r;
         wgray_sync_r <= wgray_meta_r;
      end
   end

endmodule

// [boundary_scan_tap.sv]
`timescale 1ns/1ps

// Function
// - Sample captures pin levels, core undisturbed
// - Sample accepts shifted pattern for later drive
// - Extest drives pins from scan cells
// - Extest captures input pin levels
// - Bypass puts one-bit register TDI to TDO
// - Bypass passes data, core keeps running
// - Instruction register is three bits
// - Boundary register length fixed per variant
// - Undriven test inputs read as high
module boundary_scan_tap (
   // System clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Test port
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tms_en,
   input wire logic i_tdi,
   input wire logic i_tdi_en,
   output logic o_tdo,
   output logic o_tdo_oe,
   // Pin side
   input wire logic [scan_pkg::BSR_LEN-1:0] i_pad_in,
   input wire logic [scan_pkg::BSR_LEN-1:0] i_core_out,
   output logic [scan_pkg::BSR_LEN-1:0] o_pad_out,
   // Pattern apply and mode
   input wire logic i_apply_en,
   output logic o_test_drive
);
   import scan_pkg::*;

   // ==========================================================
   // Test clock domain signals
   logic rst_meta_r, rst_tck_r;
   logic tms_eff, tdi_eff;
   tap_state_t state_r, state_nxt;
   logic [IR_W-1:0] ir_sh_r, ir_r;
   logic bypass_r;
   logic [BSR_LEN-1:0] bsr_sh_r, upd_r, hold_r;
   logic sel_bsr, ext_mode, ext_t_r;
   logic pend_r, fifo_wready;
   logic req_meta_t_r, req_sync_t_r, ack_t_r;
   logic shifting, tdo_src;

   // ==========================================================
   // System clock domain signals
   logic [BSR_LEN-1:0] pad_meta_r, pad_sync_r, mbox_r, pat_r, fifo_rdata;
   logic req_r, ack_meta_r, ack_sync_r;
   logic ext_meta_r, ext_sync_r;
   logic fifo_rvalid;

   // ==========================================================
   // Test clock reset, taken from system reset
   always_ff @(posedge i_tck)
   begin
      rst_meta_r <= i_rst;
      rst_tck_r <= rst_meta_r;
   end

   // Weak pull-up on undriven test inputs
   assign tms_eff = i_tms_en ? i_tms : 1'h1;
   assign tdi_eff = i_tdi_en ? i_tdi : 1'h1;

   // ==========================================================
   // Controller next state
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         st_tlr: state_nxt = tms_eff ? st_tlr : st_idle;
         st_idle: state_nxt = tms_eff ? st_sel_dr : st_idle;
         st_sel_dr: state_nxt = tms_eff ? st_sel_ir : st_cap_dr;
         st_cap_dr: state_nxt = tms_eff ? st_ex1_dr : st_shift_dr;
         st_shift_dr: state_nxt = tms_eff ? st_ex1_dr : st_shift_dr;
         st_ex1_dr: state_nxt = tms_eff ? st_upd_dr : st_pause_dr;
         st_pause_dr: state_nxt = tms_eff ? st_ex2_dr : st_pause_dr;
         st_ex2_dr: state_nxt = tms_eff ? st_upd_dr : st_shift_dr;
         st_upd_dr: state_nxt = tms_eff ? st_sel_dr : st_idle;
         st_sel_ir: state_nxt = tms_eff ? st_tlr : st_cap_ir;
         st_cap_ir: state_nxt = tms_eff ? st_ex1_ir : st_shift_ir;
         st_shift_ir: state_nxt = tms_eff ? st_ex1_ir : st_shift_ir;
         st_ex1_ir: state_nxt = tms_eff ? st_upd_ir : st_pause_ir;
         st_pause_ir: state_nxt = tms_eff ? st_ex2_ir : st_pause_ir;
         st_ex2_ir: state_nxt = tms_eff ? st_upd_ir : st_shift_ir;
         st_upd_ir: state_nxt = tms_eff ? st_sel_dr : st_idle;
      endcase
   end

   // Controller state on rising test clock
   always_ff @(posedge i_tck)
   begin
      if (rst_tck_r)
      begin
         state_r <= st_tlr;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // Instruction shift register
   always_ff @(posedge i_tck)
   begin
      if (rst_tck_r)
      begin
         ir_sh_r <= IR_CAPTURE_VAL;
      end
      else if (state_r == st_cap_ir)
      begin
         ir_sh_r <= IR_CAPTURE_VAL;
      end
      else if (state_r == st_shift_ir)
      begin
         ir_sh_r <= {tdi_eff, ir_sh_r[IR_W-1:1]};
      end
   end

   // Active instruction
   always_ff @(posedge i_tck)
   begin
      if (rst_tck_r || state_r == st_tlr)
      begin
         ir_r <= IR_RESET_VAL;
      end
      else if (state_r == st_upd_ir)
      begin
         ir_r <= ir_sh_r;
      end
   end

   // Instruction decode, unknown codes select bypass
   assign sel_bsr = (ir_r == INSN_EXTEST) || (ir_r == INSN_SAMPLE);
   assign ext_mode = (ir_r == INSN_EXTEST);

   // ==========================================================
   // One-bit bypass register
   always_ff @(posedge i_tck)
   begin
      if (rst_tck_r)
      begin
         bypass_r <= BYPASS_CAPTURE_VAL;
      end
      else if (state_r == st_cap_dr)
      begin
         bypass_r <= BYPASS_CAPTURE_VAL;
      end
      else if (state_r == st_shift_dr)
      begin
         bypass_r <= tdi_eff;
      end
   end

   // ==========================================================
   // Boundary shift register, pin snapshot or shifted pattern
   always_ff @(posedge i_tck)
   begin
      if (rst_tck_r)
      begin
         bsr_sh_r <= '0;
      end
      else if (state_r == st_cap_dr && sel_bsr)
      begin
         bsr_sh_r <= hold_r;
      end
      else if (state_r == st_shift_dr && sel_bsr)
      begin
         bsr_sh_r <= {tdi_eff, bsr_sh_r[BSR_LEN-1:1]};
      end
   end

   // Update register, holds the preloaded pattern
   always_ff @(posedge i_tck)
   begin
      if (rst_tck_r)
      begin
         upd_r <= '0;
      end
      else if (state_r == st_upd_dr && sel_bsr)
      begin
         upd_r <= bsr_sh_r;
      end
   end

   // Pending push, set wins over the clear when the queue has room
   always_ff @(posedge i_tck)
   begin
      if (rst_tck_r)
      begin
         pend_r <= 1'h0;
      end
      else if (state_r == st_upd_dr && sel_bsr)
      begin
         pend_r <= 1'h1;
      end
      else if (fifo_wready)
      begin
         pend_r <= 1'h0;
      end
   end

   // Mode level for the system side
   always_ff @(posedge i_tck)
   begin
      if (rst_tck_r)
      begin
         ext_t_r <= 1'h0;
      end
      else
      begin
         ext_t_r <= ext_mode;
      end
   end

   // ==========================================================
   // Snapshot handshake, test clock end
   always_ff @(posedge i_tck)
   begin
      if (rst_tck_r)
      begin
         req_meta_t_r <= 1'h0;
         req_sync_t_r <= 1'h0;
         ack_t_r <= 1'h0;
         hold_r <= '0;
      end
      else
      begin
         req_meta_t_r <= req_r;
         req_sync_t_r <= req_meta_t_r;
         if (req_sync_t_r != ack_t_r)
         begin
            hold_r <= mbox_r;
            ack_t_r <= req_sync_t_r;
         end
      end
   end

   // ==========================================================
   // Serial output on falling test clock
   assign shifting = (state_r == st_shift_ir) || (state_r == st_shift_dr);
   assign tdo_src = (state_r == st_shift_ir) ? ir_sh_r[0] :
                    (sel_bsr ? bsr_sh_r[0] : bypass_r);

   always_ff @(negedge i_tck)
   begin
      if (rst_tck_r)
      begin
         o_tdo <= 1'h0;
         o_tdo_oe <= 1'h0;
      end
      else
      begin
         o_tdo <= tdo_src;
         o_tdo_oe <= shifting;
      end
   end

   // ==========================================================
   // Pattern queue between the two clocks
   xfer_fifo #(
      .W(BSR_LEN),
      .DEPTH(XFER_DEPTH)
   ) u_xfer (
      .i_wclk(i_tck),
      .i_wrst(rst_tck_r),
      .i_wvalid(pend_r),
      .o_wready(fifo_wready),
      .i_wdata(upd_r),
      .i_rclk(i_clk),
      .i_rrst(i_rst),
      .o_rvalid(fifo_rvalid),
      .i_rready(i_apply_en),
      .o_rdata(fifo_rdata)
   );

   // ==========================================================
   // Pin input synchroniser
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pad_meta_r <= '0;
         pad_sync_r <= '0;
      end
      else
      begin
         pad_meta_r <= i_pad_in;
         pad_sync_r <= pad_meta_r;
      end
   end

   // Snapshot handshake, system end
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ack_meta_r <= 1'h0;
         ack_sync_r <= 1'h0;
         req_r <= 1'h0;
         mbox_r <= '0;
      end
      else
      begin
         ack_meta_r <= ack_t_r;
         ack_sync_r <= ack_meta_r;
         if (req_r == ack_sync_r)
         begin
            mbox_r <= pad_sync_r;
            req_r <= ~req_r;
         end
      end
   end

   // Mode synchroniser
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ext_meta_r <= 1'h0;
         ext_sync_r <= 1'h0;
      end
      else
      begin
         ext_meta_r <= ext_t_r;
         ext_sync_r <= ext_meta_r;
      end
   end

   // Pattern register, loaded from the queue
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pat_r <= '0;
      end
      else if (fifo_rvalid && i_apply_en)
      begin
         pat_r <= fifo_rdata;
      end
   end

   // Pin drivers, core path unless external test
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_pad_out <= '0;
      end
      else
      begin
         o_pad_out <= ext_sync_r ? pat_r : i_core_out;
      end
   end

   assign o_test_drive = ext_sync_r;

   // ==========================================================
   // Checks, test clock domain
   sequence s_tms_high5;
      tms_eff [*5];
   endsequence

   sequence s_upd_bsr;
      (state_r == st_upd_dr) && sel_bsr;
   endsequence

   property p_tlr_entry;
      @(posedge i_tck) disable iff (rst_tck_r)
      s_tms_high5 |=> (state_r == st_tlr);
   endproperty

   property p_preload;
      @(posedge i_tck) disable iff (rst_tck_r)
      s_upd_bsr |=> (upd_r == $past(bsr_sh_r)) && pend_r;
   endproperty

   a_tlr_five_high: assert property (p_tlr_entry)
      else $error("five high mode samples did not reset controller");

   a_ir_capture_value: assert property (
      @(posedge i_tck) disable iff (rst_tck_r)
      (state_r == st_cap_ir) |=> (ir_sh_r == IR_CAPTURE_VAL))
      else $error("instruction capture value wrong");

   a_ir_update_load: assert property (
      @(posedge i_tck) disable iff (rst_tck_r)
      (state_r == st_upd_ir) |=> (ir_r == $past(ir_sh_r)))
      else $error("instruction not loaded on update");

   a_bypass_one_bit: assert property (
      @(posedge i_tck) disable iff (rst_tck_r)
      (state_r == st_shift_dr && !sel_bsr) ##1 (state_r == st_shift_dr)
      |-> (bypass_r == $past(tdi_eff)))
      else $error("bypass bit does not follow serial input");

   a_bsr_capture_pins: assert property (
      @(posedge i_tck) disable iff (rst_tck_r)
      ((state_r == st_cap_dr) && sel_bsr) |=> (bsr_sh_r == $past(hold_r)))
      else $error("boundary capture missed pin snapshot");

   a_preload_queue: assert property (p_preload)
      else $error("preload pattern not queued on update");

   a_tdo_float: assert property (
      @(negedge i_tck) disable iff (rst_tck_r)
      !shifting |=> !o_tdo_oe)
      else $error("serial output driven outside shift");

   // ==========================================================
   // Checks, system clock domain
   a_sample_snapshot: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (req_r == ack_sync_r) |=> (mbox_r == $past(pad_sync_r)))
      else $error("snapshot mailbox not loaded");

   a_extest_drive: assert property (
      @(posedge i_clk) disable iff (i_rst)
      ext_sync_r |=> (o_pad_out == $past(pat_r)))
      else $error("pins not driven from scan pattern");

   a_normal_drive: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !ext_sync_r |=> (o_pad_out == $past(i_core_out)))
      else $error("core path disturbed outside external test");

endmodule

// [scan_ctrl_model.sv]
`timescale 1ns/1ps

// ==========================================================
// Serial test controller driving the scan port
module scan_ctrl_model (
   // Test port toward the device
   output logic o_tck,
   output logic o_tms,
   output logic o_tms_en,
   output logic o_tdi,
   output logic o_tdi_en,
   // Serial data back from the device
   input wire logic i_tdo,
   input wire logic i_tdo_oe
);
   int oe_hits;

   // Pins released, test clock parked low
   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tms_en = 1'b0;
      o_tdi = 1'b0;
      o_tdi_en = 1'b0;
      oe_hits = 0;
   end

   // One test clock period, sampling the pulled-up data line at the rise
   task automatic edge_pulse(output logic so);
      #15;
      o_tck = 1'b1;
      so = i_tdo_oe ? i_tdo : 1'b1;
      if (i_tdo_oe)
      begin
         oe_hits++;
      end
      #15;
      o_tck = 1'b0;
   endtask

   // Mode and data set while the clock is low; released data line flips
   task automatic step(input logic tms, input logic tdi, input logic den, output logic so);
      o_tms = tms;
      o_tms_en = 1'b1;
      o_tdi_en = den;
      o_tdi = den ? tdi : ~o_tdi;
      edge_pulse(so);
   endtask

   // Mode line left floating, seen high through the pull-up
   task automatic release_tms(input int n);
      logic so;
      repeat (n)
      begin
         o_tms_en = 1'b0;
         o_tms = ~o_tms;
         o_tdi_en = 1'b0;
         edge_pulse(so);
      end
   endtask

   // Run-test/idle clocks, keeps the cross-clock paths moving
   task automatic idle(input int n);
      logic so;
      repeat (n)
      begin
         step(1'b0, 1'b0, 1'b0, so);
      end
   endtask

   // Five released highs, then to idle
   task automatic reset_tap(input int n);
      logic so;
      release_tms(n);
      step(1'b0, 1'b0, 1'b0, so);
   endtask

   // From idle to a shift state
   task automatic go_shift(input logic ir);
      logic so;
      step(1'b1, 1'b0, 1'b0, so);
      if (ir)
      begin
         step(1'b1, 1'b0, 1'b0, so);
      end
      step(1'b0, 1'b0, 1'b0, so);
      step(1'b0, 1'b0, 1'b0, so);
   endtask

   // Shift n bits LSB first, then update and back to idle
   task automatic shift(input logic [299:0] din, input int n, output logic [299:0] dout);
      logic so;
      dout = '0;
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], 1'b1, so);
         dout[i] = so;
      end
      step(1'b1, 1'b0, 1'b0, so);
      step(1'b0, 1'b0, 1'b0, so);
      idle(4);
   endtask

   // Three-bit instruction load
   task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
      logic [299:0] d;
      go_shift(1'b1);
      shift({297'h0, code}, 3, d);
      cap = d[2:0];
   endtask

   task automatic scan_dr(input logic [299:0] din, input int n, output logic [299:0] dout);
      go_shift(1'b0);
      shift(din, n, dout);
   endtask
endmodule

// [boundary_scan_tap_tb_top.sv]
`timescale 1ns/1ps

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

// ==========================================================
// Bench top
module boundary_scan_tap_tb_top;
   import scan_pkg::*;
   logic clk, rst, tck, tms, tms_en, tdi, tdi_en, tdo, tdo_oe, apply_en, test_drive;
   logic [BSR_LEN-1:0] pad_in, core_out, pad_out;
   logic [2:0] cap;
   logic [299:0] d;
   int miscompares, samples_checked, h;
   localparam logic [BSR_LEN-1:0] C1 = {39{7'h13}};
   localparam logic [BSR_LEN-1:0] C2 = {39{7'h6c}};
   localparam logic [BSR_LEN-1:0] P1 = {39{7'h5a}};
   localparam logic [BSR_LEN-1:0] P2 = {39{7'h27}};
   localparam logic [BSR_LEN-1:0] Q1 = {39{7'h71}};
   localparam logic [BSR_LEN-1:0] Q2 = {39{7'h4b}};

   boundary_scan_tap DUT (.i_clk(clk), .i_rst(rst), .i_tck(tck), .i_tms(tms), .i_tms_en(tms_en),
      .i_tdi(tdi), .i_tdi_en(tdi_en), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pad_in(pad_in),
      .i_core_out(core_out), .o_pad_out(pad_out), .i_apply_en(apply_en),
      .o_test_drive(test_drive));

   scan_ctrl_model ctl (.o_tck(tck), .o_tms(tms), .o_tms_en(tms_en), .o_tdi(tdi),
      .o_tdi_en(tdi_en), .i_tdo(tdo), .i_tdo_oe(tdo_oe));

   // System clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ==========================================================
   // Shared helpers
   task automatic print_verdict();
      if (miscompares == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   function automatic logic [BSR_LEN-1:0] pat(input logic [2:0] k);
      return {91{k + 3'h1}};
   endfunction

   // Bounded wait for the pin drivers, then compare
   task automatic wait_pads(input logic [BSR_LEN-1:0] exp);
      for (int i = 0; i < 60 && pad_out !== exp; i++)
         @(negedge clk);
      `CHK(pad_out, exp)
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_bypass(input logic [2:0] code, input logic [BSR_LEN-1:0] core);
      @(negedge clk);
      core_out = core;
      ctl.load_ir(code, cap);
      `CHK(cap, IR_CAPTURE_VAL)
      h = ctl.oe_hits;
      ctl.scan_dr({292'h0, 8'hb4}, 8, d);
      `CHK(d[7:0], {7'h34, BYPASS_CAPTURE_VAL})
      `CHK(ctl.oe_hits - h, 8)
      wait_pads(core);
      `CHK(test_drive, 1'b0)
   endtask

   task automatic t_sample();
      ctl.load_ir(INSN_SAMPLE, cap);
      @(negedge clk);
      pad_in = P1;
      ctl.idle(40);
      ctl.scan_dr({19'h0, Q1, 8'h3c}, 281, d);
      `CHK(d[272:0], P1)
      `CHK(d[280:273], 8'h3c)
      wait_pads(C2);
      `CHK(test_drive, 1'b0)
   endtask

   task automatic t_extest();
      @(negedge clk);
      apply_en = 1'b0;
      for (int k = 0; k < 5; k++)
         ctl.scan_dr({27'h0, pat(k[2:0])}, 273, d);
      ctl.load_ir(INSN_EXTEST, cap);
      @(negedge clk);
      apply_en = 1'b1;
      ctl.idle(40);
      wait_pads(pat(3'h4));
      `CHK(test_drive, 1'b1)
      @(negedge clk);
      pad_in = P2;
      ctl.idle(40);
      ctl.scan_dr({19'h0, Q2, 8'h00}, 281, d);
      `CHK(d[272:0], P2)
      wait_pads(Q2);
   endtask

   task automatic t_tms_reset();
      @(negedge clk);
      core_out = C1;
      ctl.reset_tap(5);
      wait_pads(C1);
      `CHK(test_drive, 1'b0)
      ctl.scan_dr({292'h0, 8'hb4}, 8, d);
      `CHK(d[7:0], 8'h68)
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      rst = 1'b1;
      apply_en = 1'b1;
      pad_in = P2;
      core_out = C1;
      miscompares = 0;
      samples_checked = 0;
      ctl.release_tms(6);
      repeat (16) @(negedge clk);
      rst = 1'b0;
      ctl.reset_tap(5);
      t_bypass(INSN_BYPASS, C1);
      t_bypass(3'h3, C2);
      t_sample();
      t_extest();
      t_tms_reset();
      print_verdict();
   end
endmodule
